//--- ata_ctl_pkg.sv
// shared constants and types for the parallel disk port control block
// assumes a single 100 MHz core clock, mclk
package ata_ctl_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // least half period of the device data-in strobe
    localparam int STROBE_HALF_NS = 30;
    localparam int STROBE_HALF_CYC_I = (STROBE_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] STROBE_HALF_CYC = STROBE_HALF_CYC_I[CNT_W-1:0];
    localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
    localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
    localparam int DATA_W = 16;
    localparam logic [DATA_W-1:0] DATA_ZERO = 16'h0000;
    // pin synchroniser bit positions
    localparam int PIN_N = 5;
    localparam int PIN_WR = 0;
    localparam int PIN_RD = 1;
    localparam int PIN_RST = 2;
    localparam int PIN_DIAG = 3;
    localparam int PIN_DASP = 4;
    // idle level of the active-low pins
    localparam logic [PIN_N-1:0] PIN_IDLE = 5'h1F;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WRITE = 2'b01,
        ST_READ = 2'b10,
        ST_STOPPED = 2'b11
    } udma_state_t;
endpackage

//--- ata_ctl_port.sv
// device end of the parallel disk port control and handshake pins
// assumes pins are asynchronous, user side is on mclk, tristates resolved outside
`timescale 1ns/10ps
module ata_ctl_port (
    input wire logic mclk,
    input wire logic srst,
    input wire logic iowr_n,
    input wire logic iord_n,
    input wire logic reset_pin_n,
    input wire logic [ata_ctl_pkg::DATA_W-1:0] dbus_in,
    input wire logic pdiag_in_n,
    input wire logic dasp_in_n,
    output logic iordy,
    output logic iocs16_n,
    output logic intrq,
    output logic [ata_ctl_pkg::DATA_W-1:0] dbus_out,
    output logic dbus_oe,
    output logic pdiag_out_n,
    output logic pdiag_oe,
    output logic dasp_out_n,
    output logic dasp_oe,
    input wire logic udma_active,
    input wire logic udma_read,
    input wire logic rx_ready,
    input wire logic [ata_ctl_pkg::DATA_W-1:0] tx_word,
    input wire logic tx_valid,
    input wire logic [ata_ctl_pkg::DATA_W-1:0] rd_word,
    input wire logic word_xfer,
    input wire logic irq_req,
    input wire logic diag_pass,
    input wire logic drive_active,
    input wire logic slave_present,
    output logic [ata_ctl_pkg::DATA_W-1:0] wr_word,
    output logic wr_valid,
    output logic [ata_ctl_pkg::DATA_W-1:0] rx_word,
    output logic rx_valid,
    output logic tx_taken,
    output logic burst_stop,
    output logic dev_reset,
    output logic pdiag_seen,
    output logic dasp_seen
);
    import ata_ctl_pkg::*;

    logic [PIN_N-1:0] pins_s;
    logic [DATA_W-1:0] dbus_s;
    logic iowr_s;
    logic iord_s;
    logic iowr_prev;
    logic iord_prev;
    logic rst;
    logic iowr_rise;
    logic iord_edge;
    logic host_ready;
    udma_state_t state;
    udma_state_t next_state;
    logic dstrobe;
    logic pending;
    logic [CNT_W-1:0] cnt;
    logic take;

    pin_sync #(.W(PIN_N), .INIT(PIN_IDLE)) u_pins (
        .mclk(mclk),
        .srst(srst),
        .async_in({dasp_in_n, pdiag_in_n, reset_pin_n, iord_n, iowr_n}),
        .sync_out(pins_s)
    );

    pin_sync #(.W(DATA_W), .INIT(DATA_ZERO)) u_data (
        .mclk(mclk),
        .srst(srst),
        .async_in(dbus_in),
        .sync_out(dbus_s)
    );

    assign iowr_s = pins_s[PIN_WR];
    assign iord_s = pins_s[PIN_RD];
    assign rst = srst | dev_reset;
    assign iowr_rise = iowr_s & ~iowr_prev;
    assign iord_edge = iord_s ^ iord_prev;
    // HDMARDY low means the host can take data-in words
    assign host_ready = ~iord_s;
    assign take = (state == ST_READ) && tx_valid && host_ready && !pending && (cnt == CNT_ZERO);

    // hardware reset from the host pin
    always_ff @(posedge mclk) begin
        if (srst) begin
            dev_reset <= 1'b0;
        end else begin
            dev_reset <= ~pins_s[PIN_RST];
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            iowr_prev <= 1'b1;
            iord_prev <= 1'b1;
        end else begin
            iowr_prev <= iowr_s;
            iord_prev <= iord_s;
        end
    end

    // burst state
    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (udma_active) begin
                    next_state = udma_read ? ST_READ : ST_WRITE;
                end
            end
            ST_WRITE, ST_READ: begin
                if (!udma_active) begin
                    next_state = ST_IDLE;
                end else if (!iowr_s) begin
                    next_state = ST_STOPPED;
                end
            end
            ST_STOPPED: begin
                if (!udma_active) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= ST_IDLE;
            burst_stop <= 1'b0;
        end else begin
            state <= next_state;
            burst_stop <= (next_state == ST_STOPPED) && (state != ST_STOPPED);
        end
    end

    // PIO write capture on strobe negation
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_word <= DATA_ZERO;
            wr_valid <= 1'b0;
        end else begin
            wr_valid <= (state == ST_IDLE) && iowr_rise;
            if ((state == ST_IDLE) && iowr_rise) begin
                wr_word <= dbus_s;
            end
        end
    end

    // data-out burst: one word per host strobe edge
    always_ff @(posedge mclk) begin
        if (rst) begin
            rx_word <= DATA_ZERO;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= (state == ST_WRITE) && iord_edge;
            if ((state == ST_WRITE) && iord_edge) begin
                rx_word <= dbus_s;
            end
        end
    end

    // data-in burst: load word, then toggle strobe after a half period
    always_ff @(posedge mclk) begin
        if (rst || state != ST_READ) begin
            dstrobe <= 1'b0;
            pending <= 1'b0;
            cnt <= CNT_ZERO;
            tx_taken <= 1'b0;
        end else begin
            tx_taken <= take;
            if (take) begin
                pending <= 1'b1;
                cnt <= STROBE_HALF_CYC;
            end else if (cnt != CNT_ZERO) begin
                cnt <= cnt - CNT_ONE;
            end else if (pending && host_ready && iowr_s) begin
                dstrobe <= ~dstrobe;
                pending <= 1'b0;
                cnt <= STROBE_HALF_CYC;
            end
            // no word or host not ready: edges simply withheld
        end
    end

    // shared ready line: IORDY, DDMARDY# or DSTROBE
    always_ff @(posedge mclk) begin
        if (rst) begin
            iordy <= 1'b1;
        end else begin
            case (state)
                ST_IDLE: iordy <= 1'b1;
                ST_WRITE: iordy <= ~rx_ready;
                ST_READ: iordy <= dstrobe;
                ST_STOPPED: iordy <= iordy;
                default: iordy <= 1'b1;
            endcase
        end
    end

    // data bus drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            dbus_out <= DATA_ZERO;
            dbus_oe <= 1'b0;
        end else if (state == ST_READ || state == ST_STOPPED) begin
            dbus_oe <= (state == ST_READ);
            if (take) begin
                dbus_out <= tx_word;
            end
        end else begin
            dbus_oe <= (state == ST_IDLE) && !iord_s;
            dbus_out <= rd_word;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            iocs16_n <= 1'b1;
            intrq <= 1'b0;
        end else begin
            iocs16_n <= ~word_xfer;
            intrq <= irq_req;
        end
    end

    // open-drain master/slave handshake lines
    always_ff @(posedge mclk) begin
        if (rst) begin
            pdiag_out_n <= 1'b0;
            pdiag_oe <= 1'b0;
            dasp_out_n <= 1'b0;
            dasp_oe <= 1'b0;
            pdiag_seen <= 1'b0;
            dasp_seen <= 1'b0;
        end else begin
            pdiag_oe <= diag_pass;
            dasp_oe <= drive_active | slave_present;
            pdiag_seen <= ~pins_s[PIN_DIAG];
            dasp_seen <= ~pins_s[PIN_DASP];
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    sequence seq_stop_req;
        (state == ST_WRITE || state == ST_READ) && udma_active && !iowr_s;
    endsequence
    sequence seq_stop_done;
        burst_stop && state == ST_STOPPED;
    endsequence

    AST_PIO_READY: assert property ((state == ST_IDLE) |=> iordy)
        else $error("ready line negated outside burst");
    AST_PIO_WR: assert property ((state == ST_IDLE) && iowr_rise |=>
        wr_valid && wr_word == $past(dbus_s))
        else $error("write strobe data not captured");
    AST_STOP: assert property (seq_stop_req |=> seq_stop_done)
        else $error("burst not ended on stop");
    AST_STOP_QUIET: assert property ((state == ST_STOPPED) && udma_active |=>
        $stable(iordy))
        else $error("ready line moved after stop");
    AST_DMARDY: assert property ((state == ST_WRITE) |=> iordy == !$past(rx_ready))
        else $error("ready indication wrong in data-out burst");
    AST_HSTROBE: assert property ((state == ST_WRITE) && iord_edge && udma_active
        && iowr_s |=> rx_valid ##1 !rx_valid || iord_edge)
        else $error("host strobe edge not latched");
    AST_DSTROBE_GAP: assert property ((state == ST_READ) && $changed(dstrobe)
        |=> $stable(dstrobe) [*5])
        else $error("data-in strobe too fast");
    AST_DSTROBE_PAUSE: assert property ((state == ST_READ) && !host_ready |=>
        $stable(dstrobe))
        else $error("strobe toggled while host paused");
    AST_CS16: assert property (word_xfer |=> !iocs16_n)
        else $error("word indicator not low");
    AST_INTRQ: assert property (irq_req |=> intrq ##1 (intrq == $past(irq_req)))
        else $error("interrupt not raised");
    AST_PIO_RD: assert property ((state == ST_IDLE) && !iord_s |=> dbus_oe)
        else $error("read data not driven");
endmodule

//--- ata_ctl_port_tb_top.sv
// self-checking bench for the disk port control block
// assumes the host model below; open-drain lines resolved here
`timescale 1ns/10ps
module ata_ctl_port_tb_top;
    logic mclk = 1'b0;
    logic srst, iowr_n, iord_n, reset_pin_n, pdiag_in_n, dasp_in_n;
    logic [15:0] dbus_in, dbus_out, tx_word, rd_word, wr_word, rx_word;
    logic iordy, iocs16_n, intrq, dbus_oe, pdiag_out_n, pdiag_oe, dasp_out_n, dasp_oe;
    logic udma_active, udma_read, rx_ready, tx_valid, word_xfer, irq_req;
    logic diag_pass, drive_active, slave_present, wr_valid, rx_valid, tx_taken;
    logic burst_stop, dev_reset, pdiag_seen, dasp_seen, other_pd;
    logic last_rdy = 1'b1;
    int n_errors = 0, checks = 0, cycles = 0, nt = 0, nb = 0, nstb = 0, s, t;
    logic [15:0] wq[$], rq[$];

    ata_host_model host (.iowr_n(iowr_n), .iord_n(iord_n), .reset_pin_n(reset_pin_n),
        .dbus_in(dbus_in));
    ata_ctl_port uut (.*);

    // wired-low lines: either party pulls PDIAG, only this device pulls DASP
    assign pdiag_in_n = !(pdiag_oe || other_pd);
    assign dasp_in_n = !dasp_oe;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles++;
        if (wr_valid === 1'b1) wq.push_back(wr_word);
        if (rx_valid === 1'b1) rq.push_back(rx_word);
        if (tx_taken === 1'b1) nt++;
        if (burst_stop === 1'b1) nb++;
        if (iordy !== last_rdy) nstb++;
        last_rdy <= iordy;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic chk(input logic [16:0] g, input logic [16:0] e);
        checks++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, g, e);
        end
    endtask

    function automatic logic [16:0] side_outs();
        return {11'h0, iocs16_n, intrq, pdiag_oe, dasp_oe, pdiag_seen, dasp_seen};
    endfunction

    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask

    task automatic t_pio;
        host.pio_wr(16'hA5C3);
        cyc(6);
        chk({1'b0, wq.pop_front()}, 17'h0A5C3);
        chk({16'h0, iordy}, 17'h1);
        rd_word = 16'h3C5A;
        host.iord_n = 1'b0;
        cyc(5);
        chk({dbus_oe, dbus_out}, 17'h13C5A);
        host.iord_n = 1'b1;
        cyc(5);
        chk({dbus_oe, iordy, 15'h0}, 17'h08000);
    endtask

    task automatic t_side;
        {word_xfer, irq_req, diag_pass, drive_active} = 4'hF;
        cyc(5);
        chk(side_outs(), 17'h1F);
        chk({15'h0, pdiag_out_n, dasp_out_n}, 17'h0);
        {word_xfer, irq_req, diag_pass, drive_active, other_pd, slave_present} = 6'h03;
        cyc(5);
        chk(side_outs(), 17'h27);
        {other_pd, slave_present} = 2'b00;
    endtask

    task automatic t_uwr;
        {udma_active, udma_read, rx_ready} = 3'b100;
        cyc(4);
        chk({16'h0, iordy}, 17'h1);
        rx_ready = 1'b1;
        cyc(4);
        chk({16'h0, iordy}, 17'h0);
        host.hstrobe(4, 16'h1230);
        cyc(5);
        chk(17'(rq.size()), 17'h4);
        for (int i = 0; i < 4; i++) chk({1'b0, rq.pop_front()}, 17'h1230 + 17'(i));
        host.iowr_n = 1'b0;
        cyc(5);
        chk(17'(nb), 17'h1);
        {udma_active, rx_ready} = 2'b00;
        host.iowr_n = 1'b1;
        cyc(5);
        chk({16'h0, iordy}, 17'h1);
    endtask

    task automatic t_urd;
        {udma_active, udma_read, tx_valid, tx_word} = {3'b111, 16'hBEEF};
        host.hdmardy(1'b1);
        cyc(3);
        s = nstb;
        cyc(40);
        chk({dbus_oe, dbus_out}, 17'h1BEEF);
        chk({16'h0, nt >= 4 && nstb - s >= nt - 1}, 17'h1);
        host.hdmardy(1'b0);
        cyc(12);
        s = nstb;
        t = nt;
        cyc(24);
        chk({16'h0, nstb == s && nt == t}, 17'h1);
        host.hdmardy(1'b1);
        tx_valid = 1'b0;
        cyc(12);
        s = nstb;
        t = nt;
        cyc(24);
        chk({16'h0, nstb == s && nt == t}, 17'h1);
        host.hdmardy(1'b0);
        host.iowr_n = 1'b0;
        cyc(5);
        chk({dbus_oe, 15'h0, nb == 2}, 17'h1);
        {udma_active, udma_read, tx_valid} = 3'b000;
        host.iowr_n = 1'b1;
        cyc(5);
    endtask

    task automatic t_rst;
        host.reset_pin_n = 1'b0;
        irq_req = 1'b1;
        cyc(4);
        chk({15'h0, dev_reset, intrq}, 17'h2);
        host.reset_pin_n = 1'b1;
        irq_req = 1'b0;
        cyc(4);
        chk({16'h0, dev_reset}, 17'h0);
    endtask

    task automatic report_and_stop;
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        {srst, udma_active, udma_read, rx_ready, tx_valid, word_xfer, irq_req} = 7'h40;
        {diag_pass, drive_active, slave_present, other_pd} = 4'h0;
        tx_word = 16'h0000;
        rd_word = 16'h0000;
        cyc(10);
        srst = 1'b0;
        cyc(3);
        t_pio();
        t_side();
        t_uwr();
        t_urd();
        t_rst();
        report_and_stop();
    end
endmodule

//--- ata_host_model.sv
// host end of the disk port: strobes, reset pin and data-out bus
// assumes the bench sets levels between calls; link edges 62.5 ns apart
`timescale 1ns/10ps
module ata_host_model (
    output logic iowr_n,
    output logic iord_n,
    output logic reset_pin_n,
    output logic [15:0] dbus_in
);
    initial begin
        iowr_n = 1'b1;
        iord_n = 1'b1;
        reset_pin_n = 1'b1;
        dbus_in = 16'h0000;
    end
    // write strobe, data held past the rising edge
    task automatic pio_wr(input logic [15:0] d);
        dbus_in = d;
        iowr_n = 1'b0;
        #60;
        iowr_n = 1'b1;
        #30;
        dbus_in = ~d;
    endtask
    // one word per edge, both edges; bus flips once hold is over
    task automatic hstrobe(input int n, input logic [15:0] base);
        for (int i = 0; i < n; i++) begin
            dbus_in = base + 16'(i);
            #22;
            iord_n = ~iord_n;
            #38;
            dbus_in = ~dbus_in;
            #2.5;
        end
    endtask
    // data-in pacing: read line low while the host can take words
    task automatic hdmardy(input logic ready);
        iord_n = !ready;
    endtask
endmodule

//--- pin_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes inputs are asynchronous to mclk
`timescale 1ns/10ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] INIT = '0
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] sync_out
);
    logic [W-1:0] meta;

    always_ff @(posedge mclk) begin
        if (srst) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule
